// ### core/phy_link_control_led.sv
// link resolution, status registers and indicators for two phy ports
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "phy_link_cfg.svh"
module phy_link_control_led #(
  parameter int unsigned BLINK_CYCLES = `BLINK_CYCLES
) (
  input  wire logic                 core_clk_i,         // 100 MHz clock
  input  wire logic                 reset_n_i,          // async reset, low
  input  wire phy_link_pkg::reg_addr_type reg_addr_i,   // register address
  input  wire phy_link_pkg::reg_word_type reg_wdata_i,  // write data
  input  wire logic                 reg_write_i,        // write strobe
  input  wire logic                 reg_read_i,         // read strobe
  output phy_link_pkg::reg_word_type reg_rdata_o,       // read data, +1 cycle
  input  wire logic                 filter_strap_pin_i, // filter strap
  input  wire logic [1:0]           energy_detect_i,    // line energy seen
  input  wire logic [1:0]           partner_negotiates_i, // pages seen
  input  wire logic [1:0]           detect_speed_100_i, // fixed 100 signal
  input  wire logic [1:0][15:0]     partner_page_i,     // partner base page
  input  wire logic [1:0][15:0]     partner_next_page_i, // energy save page
  input  wire logic [1:0]           line_activity_i,    // rx or tx traffic
  input  wire logic [1:0][6:0]      quality_raw_i,      // raw quality level
  input  wire logic [1:0][7:0]      cable_delay_i,      // reflection time
  output logic      [1:0]           link_up_o,          // link established
  output logic      [1:0]           speed_100_o,        // 1 = 100 Mb/s
  output logic      [1:0]           full_duplex_o,      // 1 = full duplex
  output logic      [1:0]           remote_loopback_o,  // loop line data
  output logic                      filter_enable_o,    // emission filter
  output logic      [1:0]           port_indicator_primary_o,   // low lit
  output logic      [1:0]           port_indicator_secondary_o  // low lit
);
  import phy_link_pkg::*;

  localparam int SYNC_W = 51;

  // reset release through two flops
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // strap capture; software overrides once it writes
  logic       strap_meta;
  logic       strap_q;
  logic [1:0] startup;
  logic       filter_sw_set;
  logic       filter_wr;

  assign filter_wr = reg_write_i && (reg_addr_i == `REG_FILTER_ADDR);

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_meta <= 1'b0;
      strap_q    <= 1'b0;
    end
    else
    begin
      strap_meta <= filter_strap_pin_i;
      strap_q    <= strap_meta;
    end
  end

  // load the strap once the synchroniser has settled
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startup         <= 2'h0;
      filter_sw_set   <= 1'b0;
      filter_enable_o <= 1'b0;
    end
    else
    begin
      if (startup != 2'h3)
        startup <= startup + 2'h1;
      if (filter_wr)
      begin
        filter_sw_set   <= 1'b1;
        filter_enable_o <= reg_wdata_i[0];
      end
      else if (startup == 2'h2 && !filter_sw_set)
        filter_enable_o <= strap_q;
    end
  end

  // shared quality refresh tick
  logic [7:0] quality_count;
  logic       quality_tick;

  assign quality_tick = (quality_count == 8'(`QUALITY_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      quality_count <= 8'h00;
    else if (quality_tick)
      quality_count <= 8'h00;
    else
      quality_count <= quality_count + 8'h01;
  end

  // pick the best common mode: {ok, speed_100, full}
  function automatic logic [2:0] resolve_mode(input logic [15:0] ours,
                                              input logic [15:0] theirs);
    logic [15:0] common;
    common = ours & theirs;
    if (common[`ADV_100_FULL])
      resolve_mode = 3'b111;
    else if (common[`ADV_100_HALF])
      resolve_mode = 3'b110;
    else if (common[`ADV_10_FULL])
      resolve_mode = 3'b101;
    else if (common[`ADV_10_HALF])
      resolve_mode = 3'b100;
    else
      resolve_mode = 3'b000;
  endfunction

  reg_word_type   ctrl      [2];
  reg_word_type   adv       [2];
  reg_word_type   partner   [2];
  reg_word_type   expand    [2];
  reg_word_type   eee_adv   [2];
  reg_word_type   eee_part  [2];
  reg_word_type   loop_reg  [2];
  reg_word_type   led_mode  [2];
  logic [6:0]     receive_quality_value [2];
  logic [7:0]     cable_value [2];
  logic [1:0]     an_done;
  link_state_type state [2];
  reg_word_type   port_rdata [2];

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      logic [SYNC_W-1:0] sync_meta;
      logic [SYNC_W-1:0] sync_q;
      logic              energy;
      logic              part_an;
      logic              det_100;
      logic              activity;
      logic [15:0]       page;
      logic [15:0]       next_page;
      logic [6:0]        quality;
      logic [7:0]        cable;
      logic [9:0]        settle;
      logic [2:0]        mode;
      logic              sel;
      logic              ctrl_wr;
      logic              force_down;

      // pins from the analog side pass two flops first
      always_ff @(posedge core_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync_meta <= '0;
          sync_q    <= '0;
        end
        else
        begin
          sync_meta <= {energy_detect_i[p], partner_negotiates_i[p],
                        detect_speed_100_i[p], line_activity_i[p],
                        partner_page_i[p], partner_next_page_i[p],
                        quality_raw_i[p], cable_delay_i[p]};
          sync_q    <= sync_meta;
        end
      end
      assign {energy, part_an, det_100, activity, page, next_page,
              quality, cable} = sync_q;

      assign sel     = (reg_addr_i[7:6] == 2'h0) && (reg_addr_i[5] == p);
      assign ctrl_wr = reg_write_i && sel &&
                       (reg_addr_i[4:0] == `REG_BASIC_CTRL);
      assign mode    = resolve_mode(adv[p], page);

      // live speed or an change drops link
      assign force_down = ctrl_wr && (reg_wdata_i[`CTRL_AN_RESTART] ||
        reg_wdata_i[`CTRL_SOFT_RESET] ||
        (state[p] == LINK_UP &&
         (reg_wdata_i[`CTRL_SPEED_100] != ctrl[p][`CTRL_SPEED_100] ||
          reg_wdata_i[`CTRL_AN_ENABLE] != ctrl[p][`CTRL_AN_ENABLE])));

      // software registers; restart and reset bits self clear
      always_ff @(posedge core_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ctrl[p]     <= `CTRL_RESET;
          adv[p]      <= `ADV_RESET;
          eee_adv[p]  <= `EEE_ADV_RESET;
          loop_reg[p] <= 16'h0000;
          led_mode[p] <= 16'h0000;
        end
        else if (ctrl_wr && reg_wdata_i[`CTRL_SOFT_RESET])
        begin
          ctrl[p] <= `CTRL_RESET;
          adv[p]  <= `ADV_RESET;
        end
        else if (reg_write_i && sel)
        begin
          case (reg_addr_i[4:0])
            `REG_BASIC_CTRL:  ctrl[p] <= reg_wdata_i & `CTRL_LIVE_MASK;
            `REG_AN_ADV:      adv[p] <= reg_wdata_i;
            `REG_EEE_ADV:     eee_adv[p] <= reg_wdata_i;
            `REG_REMOTE_LOOP: loop_reg[p] <= reg_wdata_i;
            `REG_LED_MODE:    led_mode[p] <= reg_wdata_i;
            default:          ;
          endcase
        end
      end

      // link resolution; settings sampled at link up
      always_ff @(posedge core_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          state[p]         <= LINK_DOWN;
          settle           <= 10'h000;
          link_up_o[p]     <= 1'b0;
          speed_100_o[p]   <= 1'b0;
          full_duplex_o[p] <= 1'b0;
          an_done[p]       <= 1'b0;
          partner[p]       <= 16'h0000;
          expand[p]        <= 16'h0000;
          eee_part[p]      <= 16'h0000;
        end
        else if (force_down)
        begin
          state[p]     <= LINK_DOWN;
          link_up_o[p] <= 1'b0;
          an_done[p]   <= 1'b0;
        end
        else
        begin
          case (state[p])
            LINK_DOWN:
            begin
              link_up_o[p] <= 1'b0;
              an_done[p]   <= 1'b0;
              settle       <= 10'h000;
              if (energy)
                state[p] <= LINK_SETTLE;
            end
            LINK_SETTLE:
            begin
              settle <= settle + 10'h001;
              if (!energy)
                state[p] <= LINK_DOWN;
              else if (settle == 10'(`SETTLE_CYCLES - 1))
              begin
                if (ctrl[p][`CTRL_AN_ENABLE] && part_an)
                begin
                  // both sides compared; best common mode wins
                  if (mode[2])
                  begin
                    state[p]         <= LINK_UP;
                    link_up_o[p]     <= 1'b1;
                    speed_100_o[p]   <= mode[1];
                    full_duplex_o[p] <= mode[0];
                    an_done[p]       <= 1'b1;
                    partner[p]       <= page;
                    expand[p]        <= 16'h0003;
                    eee_part[p]      <= next_page;
                  end
                  else
                    state[p] <= LINK_DOWN;
                end
                else if (ctrl[p][`CTRL_AN_ENABLE])
                begin
                  // partner silent: parallel detection, half duplex
                  state[p]         <= LINK_UP;
                  link_up_o[p]     <= 1'b1;
                  speed_100_o[p]   <= det_100;
                  full_duplex_o[p] <= 1'b0;
                  partner[p]       <= 16'h0000;
                  expand[p]        <= 16'h0000;
                  eee_part[p]      <= 16'h0000;
                end
                else
                begin
                  state[p]         <= LINK_UP;
                  link_up_o[p]     <= 1'b1;
                  speed_100_o[p]   <= ctrl[p][`CTRL_SPEED_100];
                  full_duplex_o[p] <= ctrl[p][`CTRL_DUPLEX];
                end
              end
            end
            LINK_UP:
            begin
              // duplex or pause edits wait for restart or relink
              if (!energy)
              begin
                state[p]     <= LINK_DOWN;
                link_up_o[p] <= 1'b0;
                an_done[p]   <= 1'b0;
              end
            end
            default:
              state[p] <= LINK_DOWN;
          endcase
        end
      end

      // readouts refreshed without hysteresis
      always_ff @(posedge core_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          receive_quality_value[p] <= 7'h00;
          cable_value[p]           <= 8'h00;
        end
        else
        begin
          if (quality_tick)
            receive_quality_value[p] <= quality;
          cable_value[p] <= cable;
        end
      end

      // loopback only meaningful on a full duplex link
      always_ff @(posedge core_clk_i or negedge rst_n)
      begin
        if (!rst_n)
          remote_loopback_o[p] <= 1'b0;
        else
          remote_loopback_o[p] <= loop_reg[p][`LOOP_ENABLE] &&
                                  link_up_o[p] && full_duplex_o[p];
      end

      // per-port read mux
      always_comb
      begin
        case (reg_addr_i[4:0])
          `REG_BASIC_CTRL:  port_rdata[p] = ctrl[p];
          `REG_BASIC_STAT:  port_rdata[p] = `STAT_ABILITY |
                              {10'h000, an_done[p], 2'h0,
                               link_up_o[p], 2'h0};
          `REG_AN_ADV:      port_rdata[p] = adv[p];
          `REG_AN_PARTNER:  port_rdata[p] = partner[p];
          `REG_AN_EXPAND:   port_rdata[p] = expand[p];
          `REG_EEE_ADV:     port_rdata[p] = eee_adv[p];
          `REG_EEE_PARTNER: port_rdata[p] = eee_part[p];
          `REG_REMOTE_LOOP: port_rdata[p] = loop_reg[p];
          `REG_QUALITY:     port_rdata[p] = {9'h000,
                                             receive_quality_value[p]};
          `REG_CABLE:       port_rdata[p] = {8'h00, cable_value[p]};
          `REG_LED_MODE:    port_rdata[p] = led_mode[p];
          default:          port_rdata[p] = 16'h0000;
        endcase
      end

      phy_led_driver #(
        .BLINK_CYCLES (BLINK_CYCLES)
      ) u_led (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n),
        .link_up_i     (link_up_o[p]),
        .speed_100_i   (speed_100_o[p]),
        .activity_i    (activity),
        .single_mode_i (led_mode[p][`LED_SINGLE]),
        .primary_n_o   (port_indicator_primary_o[p]),
        .secondary_n_o (port_indicator_secondary_o[p])
      );
    end
  endgenerate

  // read data stands one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= 16'h0000;
    else if (!reg_read_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_addr_i == `REG_FILTER_ADDR)
      reg_rdata_o <= {15'h0000, filter_enable_o};
    else if (reg_addr_i[7:6] == 2'h0)
      reg_rdata_o <= port_rdata[reg_addr_i[5]];
    else
      reg_rdata_o <= 16'h0000;
  end
endmodule
`default_nettype wire

// ### core/phy_link_cfg.svh
// constants for the link control block
//
// Overview of operation
// - resolution ranks 100 full, 100 half, 10 full, 10 half
// - adopt the best mode both sides advertise after comparing abilities
// - without partner negotiation, take the mode seen at the receiver
// - energy-saving ability travels in next-page messages
// - negotiation on after reset; control bit 12 turns it on or off
// - negotiation off: speed from control bit 13, duplex from bit 8
// - a speed change on a live link drops it and re-resolves
// - other changes apply only after restart bit 9 or a relink; a bit 12 change drops a live link at once
// - on completion update link status, partner and expansion registers
// - emission filter set by strap at reset, software write overrides
// - remote loopback resends received line data, full duplex only
// - quality value readable anytime, refreshed at fixed interval
// - cable reflection timing readable as a plain number
// - per-port indicator mode bit 4: 1 single, 0 tri-color default
// - all indicator outputs are active low
// - single: secondary lit on link, primary idle high, blinks on traffic
// - tri-color: no link both high; 100 Mb/s uses primary only
// - tri-color 10 Mb/s: both together; secondary-only never shown
`ifndef PHY_LINK_CFG_SVH
`define PHY_LINK_CFG_SVH

// register indices inside one port window
`define REG_BASIC_CTRL  5'h00
`define REG_BASIC_STAT  5'h01
`define REG_AN_ADV      5'h04
`define REG_AN_PARTNER  5'h05
`define REG_AN_EXPAND   5'h06
`define REG_EEE_ADV     5'h10
`define REG_EEE_PARTNER 5'h11
`define REG_REMOTE_LOOP 5'h12
`define REG_QUALITY     5'h13
`define REG_CABLE       5'h14
`define REG_LED_MODE    5'h15
`define REG_FILTER_ADDR 8'h40

// control field positions
`define CTRL_SOFT_RESET 15
`define CTRL_SPEED_100  13
`define CTRL_AN_ENABLE  12
`define CTRL_AN_RESTART 9
`define CTRL_DUPLEX     8
`define ADV_100_FULL    8
`define ADV_100_HALF    7
`define ADV_10_FULL     6
`define ADV_10_HALF     5
`define STAT_AN_DONE    5
`define STAT_LINK       2
`define LOOP_ENABLE     8
`define LED_SINGLE      4

// reset values, status ability bits and control write mask
`define CTRL_RESET      16'h3100
`define ADV_RESET       16'h01e1
`define EEE_ADV_RESET   16'h0002
`define STAT_ABILITY    16'h7808
`define CTRL_LIVE_MASK  16'h7dff

// timing
`define CLK_PERIOD_NS   10
`define SETTLE_NS       10000
`define SETTLE_CYCLES   (`SETTLE_NS / `CLK_PERIOD_NS)
`define QUALITY_NS      2000
`define QUALITY_CYCLES  (`QUALITY_NS / `CLK_PERIOD_NS)
`define BLINK_MS        30
`define BLINK_CYCLES    (`BLINK_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ### core/phy_link_pkg.sv
// types shared by the link control block
package phy_link_pkg;
  typedef enum logic [1:0] {LINK_DOWN, LINK_SETTLE, LINK_UP} link_state_type;
  typedef logic [15:0] reg_word_type;
  typedef logic [7:0]  reg_addr_type;
endpackage

// ### core/phy_led_driver.sv
// indicator pair driver for one port
`timescale 1ns/100ps
`default_nettype none
module phy_led_driver #(
  parameter int unsigned BLINK_CYCLES = 3000000
) (
  input  wire logic core_clk_i,      // device clock
  input  wire logic rst_n_i,         // synchronised reset, low active
  input  wire logic link_up_i,       // resolved link state
  input  wire logic speed_100_i,     // resolved speed
  input  wire logic activity_i,      // synchronised rx or tx activity
  input  wire logic single_mode_i,   // 1 single, 0 tri-color
  output logic      primary_n_o,     // primary indicator, low lights
  output logic      secondary_n_o    // secondary indicator, low lights
);
  import phy_link_pkg::*;

  logic [21:0] tick_count;
  logic        tick;
  logic        pending;
  logic        blink;

  assign tick = (tick_count == 22'(BLINK_CYCLES - 1));

  // free running blink period
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_count <= 22'h000000;
    else if (tick)
      tick_count <= 22'h000000;
    else
      tick_count <= tick_count + 22'h000001;
  end

  // stretch bursts so one frame still gives a visible blink
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pending <= 1'b0;
    else
      pending <= activity_i | (pending & ~tick);
  end

  // blink phase toggles per period of traffic
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      blink <= 1'b0;
    else if (!link_up_i)
      blink <= 1'b0;
    else if (tick)
      blink <= pending ? ~blink : 1'b0;
  end

  // outputs low active; secondary never lit alone in tri-color
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      primary_n_o   <= 1'b1;
      secondary_n_o <= 1'b1;
    end
    else if (single_mode_i)
    begin
      secondary_n_o <= ~link_up_i;
      primary_n_o   <= ~blink;
    end
    else if (!link_up_i)
    begin
      primary_n_o   <= 1'b1;
      secondary_n_o <= 1'b1;
    end
    else if (speed_100_i)
    begin
      primary_n_o   <= blink;
      secondary_n_o <= 1'b1;
    end
    else
    begin
      primary_n_o   <= blink;
      secondary_n_o <= blink;
    end
  end
endmodule
`default_nettype wire

// ### verif/phy_link_control_led_checker.sv
// port-level checker for the link block
`timescale 1ns/100ps
`default_nettype none
module phy_link_control_led_checker (
  input wire logic                       core_clk_i,        // clock
  input wire logic                       reset_n_i,         // reset, low
  input wire phy_link_pkg::reg_addr_type reg_addr_i,        // address
  input wire phy_link_pkg::reg_word_type reg_wdata_i,       // write data
  input wire logic                       reg_write_i,       // write
  input wire logic                       reg_read_i,        // read
  input wire phy_link_pkg::reg_word_type reg_rdata_o,       // read data
  input wire logic [1:0]                 link_up_o,         // link
  input wire logic [1:0]                 speed_100_o,       // speed
  input wire logic [1:0]                 full_duplex_o,     // duplex
  input wire logic [1:0]                 remote_loopback_o, // loop on
  input wire logic [1:0]                 port_indicator_primary_o,   // led
  input wire logic [1:0]                 port_indicator_secondary_o  // led
);
  import phy_link_pkg::*;
  logic single_q; // port 0 indicator mode
  // mode bit shadowed from bus writes
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      single_q <= 1'b0;
    else if (reg_write_i && reg_addr_i == 8'h15)
      single_q <= reg_wdata_i[4];
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // mode settled before the pair is judged
  sequence tri_settled;
    (!single_q)[*3];
  endsequence
  sequence single_settled;
    single_q[*3];
  endsequence
  loop_needs_link_a: assert property (
    remote_loopback_o[0] |-> $past(link_up_o[0] && full_duplex_o[0]))
    else $error("loop without link");
  nolink_sec_off_a: assert property (
    (!link_up_o[0])[*2] |-> port_indicator_secondary_o[0])
    else $error("secondary lit");
  restart_drops_a: assert property (
    reg_write_i && reg_addr_i == 8'h00 && reg_wdata_i[9] && link_up_o[0]
    |-> ##[1:3] !link_up_o[0])
    else $error("restart kept link");
  speed_drops_a: assert property (
    reg_write_i && reg_addr_i == 8'h00 && !reg_wdata_i[12] && link_up_o[0]
    && reg_wdata_i[13] != speed_100_o[0] |-> ##[1:3] !link_up_o[0])
    else $error("speed change kept link");
  status_read_a: assert property (
    reg_read_i && reg_addr_i == 8'h01 |=> reg_rdata_o[15:11] == 5'h0f
    && reg_rdata_o[2] == $past(link_up_o[0]))
    else $error("status read wrong");
  tri_reserved_a: assert property (
    tri_settled ##0 !port_indicator_secondary_o[0]
    |-> !port_indicator_primary_o[0])
    else $error("reserved pattern");
  single_link_a: assert property (
    single_settled ##0 link_up_o[0][*2] |-> !port_indicator_secondary_o[0])
    else $error("link indicator dark");
  tri_fast_a: assert property (
    tri_settled ##0 (link_up_o[0] && speed_100_o[0])[*2]
    |-> port_indicator_secondary_o[0])
    else $error("secondary on fast link");
endmodule
`default_nettype wire

// ### verif/link_partner_model.sv
// behavioural far-end phy for both ports
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
  input  wire logic       core_clk_i,  // clock
  input  wire logic [1:0] plug_i,      // cable present
  input  wire logic [1:0] negotiate_i, // partner negotiates
  input  wire logic [1:0] fast_i,      // fixed signal is 100
  input  wire logic [15:0] ability_i,  // advertised abilities
  input  wire logic [1:0] traffic_i,   // frames wanted
  output logic [1:0]       energy_o,   // energy at receiver
  output logic [1:0]       nego_o,     // pages on the line
  output logic [1:0]       fast_o,     // fixed 100 signal
  output logic [1:0][15:0] page_o,     // base page
  output logic [1:0][15:0] next_page_o, // energy save page
  output logic [1:0]       activity_o, // traffic pulses
  output logic [1:0][6:0]  quality_o,  // quality level
  output logic [1:0][7:0]  cable_o     // reflection time
);
  logic [2:0] beat = 3'h0; // frame spacing
  // unplugged lines show wandering pages
  always_ff @(posedge core_clk_i)
  begin
    beat <= beat + 3'h1;
    energy_o <= plug_i;
    nego_o <= plug_i & negotiate_i;
    fast_o <= fast_i;
    activity_o <= traffic_i & {2{beat == 3'h0}}; // short frames
    for (int p = 0; p < 2; p++)
    begin
      page_o[p] <= plug_i[p] ? ability_i : {8{beat[0], ~beat[0]}};
      next_page_o[p] <= plug_i[p] ? 16'h0006 : {8{~beat[0], beat[0]}};
    end
  end
  assign quality_o = {7'h05, 7'h05};
  assign cable_o = {8'h2a, 8'h2a};
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the link block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import phy_link_pkg::*;
  localparam int BLINK = 16; // short blink
  logic core_clk_i, reset_n_i, reg_write_i, reg_read_i, filter_strap_pin_i;
  logic filter_enable_o;
  reg_addr_type reg_addr_i;
  reg_word_type reg_wdata_i, reg_rdata_o;
  logic [1:0] energy_detect_i, partner_negotiates_i, detect_speed_100_i;
  logic [1:0] line_activity_i, link_up_o, speed_100_o, full_duplex_o;
  logic [1:0] remote_loopback_o, port_indicator_primary_o;
  logic [1:0] port_indicator_secondary_o, plug, nego, fast, traffic;
  logic [1:0][15:0] partner_page_i, partner_next_page_i;
  logic [1:0][6:0] quality_raw_i;
  logic [1:0][7:0] cable_delay_i;
  logic [15:0] ability;
  int err_count, checks_done;
  phy_link_control_led #(.BLINK_CYCLES(BLINK)) DUT (.*);
  link_partner_model partner (
    .core_clk_i, .plug_i(plug), .negotiate_i(nego), .fast_i(fast),
    .ability_i(ability), .traffic_i(traffic), .energy_o(energy_detect_i),
    .nego_o(partner_negotiates_i), .fast_o(detect_speed_100_i),
    .page_o(partner_page_i), .next_page_o(partner_next_page_i),
    .activity_o(line_activity_i), .quality_o(quality_raw_i),
    .cable_o(cable_delay_i));
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobes; read data next cycle
  task automatic wr(input reg_addr_type a, input reg_word_type d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd_chk(input reg_addr_type a, input reg_word_type exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 check(reg_rdata_o, exp);
  endtask
  function automatic logic [15:0] leds(input int p);
    return {14'h0, port_indicator_primary_o[p], port_indicator_secondary_o[p]};
  endfunction
  function automatic logic [15:0] mode(input int p);
    return {14'h0, speed_100_o[p], full_duplex_o[p]};
  endfunction
  // bound well above the settle time
  task automatic wait_link(input int p, input logic want);
    int n = 0;
    while (link_up_o[p] !== want && n < 3000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 3000)
    begin
      err_count++;
      give_verdict();
    end
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic t_reset();
    check(16'(filter_enable_o), 16'h1);
    check(leds(0), 16'h3);
    rd_chk(8'h00, 16'h3100);
    rd_chk(8'h80, 16'h0000);
    wr(8'h40, 16'h0000);
    repeat (3) @(posedge core_clk_i);
    check(16'(filter_enable_o), 16'h0);
  endtask
  task automatic t_negotiate();
    plug <= 2'b01;
    wait_link(0, 1'b1);
    check(mode(0), 16'h2);
    rd_chk(8'h01, 16'h782c);
    rd_chk(8'h05, 16'h00c1);
    rd_chk(8'h11, 16'h0006);
    rd_chk(8'h13, 16'h0005);
    rd_chk(8'h14, 16'h002a);
    check(leds(0), 16'h1);
  endtask
  task automatic t_parallel();
    plug <= 2'b11;
    wait_link(1, 1'b1);
    check(mode(1), 16'h0);
    rd_chk(8'h26, 16'h0000);
    check(leds(1), 16'h0);
  endtask
  task automatic t_restart();
    wr(8'h04, 16'h0041);
    repeat (20) @(posedge core_clk_i);
    check(mode(0), 16'h2);
    wr(8'h00, 16'h3300);
    wait_link(0, 1'b0);
    wait_link(0, 1'b1);
    check(mode(0), 16'h1);
    wr(8'h00, 16'h2100);
    wait_link(0, 1'b0);
    wait_link(0, 1'b1);
    check(mode(0), 16'h3);
    rd_chk(8'h00, 16'h2100);
    wr(8'h00, 16'h8000);
    rd_chk(8'h04, 16'h01e1);
  endtask
  task automatic t_loop(input reg_word_type adv, input logic [15:0] exp);
    ability <= 16'h01e1;
    wr(8'h04, adv);
    wr(8'h12, 16'h01f0);
    wr(8'h00, 16'h3300);
    wait_link(0, 1'b0);
    wait_link(0, 1'b1);
    check(mode(0), exp);
    check(16'(remote_loopback_o[0]), 16'h1);
  endtask
  task automatic t_led();
    logic lit = 1'b0;
    wr(8'h15, 16'h0010);
    repeat (3) @(posedge core_clk_i);
    check(leds(0), 16'h2);
    rd_chk(8'h15, 16'h0010);
    traffic <= 2'b11;
    repeat (4 * BLINK)
    begin
      @(posedge core_clk_i);
      #1 lit |= !port_indicator_primary_o[0];
    end
    check(16'(lit), 16'h1);
    traffic <= 2'b00;
    repeat (4 * BLINK) @(posedge core_clk_i);
    check(leds(0), 16'h2);
    plug <= 2'b10;
    wait_link(0, 1'b0);
    check(leds(0), 16'h3);
  endtask
  initial
  begin
    err_count = 0;
    checks_done = 0;
    reset_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    filter_strap_pin_i = 1'b1;
    plug = 2'b00;
    nego = 2'b01;
    fast = 2'b00;
    traffic = 2'b00;
    ability = 16'h00c1;
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    t_reset();
    t_negotiate();
    t_parallel();
    t_restart();
    t_loop(16'h0181, 16'h0003);
    t_loop(16'h0061, 16'h0001);
    t_led();
    give_verdict();
  end
endmodule
bind phy_link_control_led phy_link_control_led_checker chk (.*);
`default_nettype wire
